// *** inc/gpio_pkg.sv ***
// package: register map, reset values and bus types of the 8-pin gpio port
package gpio_pkg;
  // ==========================================================================
  // geometry
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_W = 6;
  // edges after reset release before edge detection trusts the pin level
  localparam int unsigned EDGE_ARM_CYCLES = 5;
  // ==========================================================================
  // register byte offsets (each register one aligned word)
  localparam logic [ADDR_W-1:0] OFF_PORT_OUTPUT_DATA = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_PORT_PIN_INPUT = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_PIN_DIRECTION = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_STRENGTH_SELECT = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_PULL_ENABLE = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PULL_AND_EDGE_POLARITY = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_EDGE_IRQ_ENABLE = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_EDGE_IRQ_FLAGS = 6'h1c;
  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_PORT_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH_SELECT = 8'h00;
  localparam logic [7:0] RST_PULL_ENABLE = 8'h00;
  localparam logic [7:0] RST_PULL_AND_EDGE_POLARITY = 8'h00;
  localparam logic [7:0] RST_EDGE_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_EDGE_IRQ_FLAGS = 8'h00;
  // ==========================================================================
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // per-pin pad control bundle
  typedef struct packed {
    logic [7:0] out_value; // level driven when enabled
    logic [7:0] out_enable; // high while the pad is driven
    logic [7:0] reduced_drive; // weak output strength
    logic [7:0] pull_on; // pull device active
    logic [7:0] pull_down; // 1 pull-down, 0 pull-up
  } pad_ctrl_t;
  // register set seen by the edge detector
  typedef struct packed {
    logic [7:0] rising; // 1 rising edge, 0 falling edge
    logic [7:0] enable; // flag unmask
  } edge_cfg_t;
endpackage : gpio_pkg

// *** rtl/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PIN_COUNT-1:0] pin_raw,
  output logic [PIN_COUNT-1:0] pin_clean
);
  // ==========================================================================
  // synchroniser stages
  logic [PIN_COUNT-1:0] s1_q; // metastable stage, read only by s2
  logic [PIN_COUNT-1:0] s2_q;
  logic [PIN_COUNT-1:0] s3_q;
  logic [PIN_COUNT-1:0] clean_q; // accepted level
  logic [PIN_COUNT-1:0] clean_d;

  // a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign clean_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : clean_q[g];
    end
  endgenerate

  // shift chain; reset keeps constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      clean_q <= 8'h00;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign pin_clean = clean_q;
endmodule : pin_sync

// *** rtl/edge_flags.sv ***
// per-pin edge detection and sticky write-one-to-clear flags
`timescale 1ns/1ps
module edge_flags
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PIN_COUNT-1:0] pin_level,
  input wire edge_cfg_t cfg,
  input wire logic [PIN_COUNT-1:0] clear_mask,
  output logic [PIN_COUNT-1:0] flags,
  output logic irq
);
  // ==========================================================================
  // state
  logic [PIN_COUNT-1:0] prev_q; // level one cycle back
  // the synchroniser restarts at zero, so a pin held high would look like
  // an edge a few cycles after release; detection waits until the level is
  // real, and an edge inside that window is not seen
  logic [EDGE_ARM_CYCLES-1:0] arm_q; // fills with ones after release
  logic [PIN_COUNT-1:0] flag_q;
  logic [PIN_COUNT-1:0] flag_d;
  logic [PIN_COUNT-1:0] hit; // active edge seen this cycle

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_edge
      // polarity picks the edge; direction plays no part
      assign hit[g] = arm_q[EDGE_ARM_CYCLES-1] & (cfg.rising[g] ? (pin_level[g] & ~prev_q[g])
                                                : (~pin_level[g] & prev_q[g]));
      // an edge beats a clear in the same cycle
      assign flag_d[g] = hit[g] | (flag_q[g] & ~clear_mask[g]);
    end
  endgenerate

  // flags and history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 8'h00;
      arm_q <= {EDGE_ARM_CYCLES{1'b0}};
      flag_q <= RST_EDGE_IRQ_FLAGS;
    end else begin
      prev_q <= pin_level;
      arm_q <= {arm_q[EDGE_ARM_CYCLES-2:0], 1'b1};
      flag_q <= flag_d;
    end
  end

  assign flags = flag_q;
  assign irq = |(flag_q & cfg.enable);
endmodule : edge_flags

// *** rtl/gpio_port.sv ***
// gpio port top: axi4-lite register slave, pad control and pin interrupt
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // pins
  // pin_oe high means the port drives the pin
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  // function routing and pad controls
  // tie alt_owns low where no other function shares a pin
  input wire logic [PIN_COUNT-1:0] alt_owns,
  input wire logic [PIN_COUNT-1:0] alt_out,
  input wire logic [PIN_COUNT-1:0] alt_oe,
  output logic [PIN_COUNT-1:0] pad_reduced_drive,
  output logic [PIN_COUNT-1:0] pad_pull_on,
  output logic [PIN_COUNT-1:0] pad_pull_down,
  // interrupt request
  output logic port_irq
);
  // ==========================================================================
  // software registers
  // one byte per register; upper read bits are zero
  logic [7:0] port_output_data_q;
  logic [7:0] pin_direction_q;
  logic [7:0] drive_strength_select_q;
  logic [7:0] pull_enable_q;
  logic [7:0] pull_and_edge_polarity_q;
  logic [7:0] edge_irq_enable_q;
  logic [7:0] edge_irq_flags; // held inside edge_flags

  // register map, one aligned word each, byte lane 0 only:
  //   0x00 output latch; reads latch or pin by direction
  //   0x04 synchronised pin state; read only
  //   0x08 direction; 1 drives the pin
  //   0x0c reduced drive; matters on driven pins
  //   0x10 pull enable; matters on undriven pins
  //   0x14 pull polarity, also the interrupt edge
  //   0x18 interrupt enable
  //   0x1c interrupt flags; write one to clear

  // ==========================================================================
  // write channel state: address and data captured in either order
  // address half, parked until the data half arrives
  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  // data half, parked until the address half arrives
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // response register; one write outstanding at most
  logic bvalid_q;
  logic [1:0] bresp_q;

  // a write completes at the edge where its later half is taken;
  // bvalid rises at that edge and stands until bready.
  // trade-off: nothing is taken while a response waits, which costs
  // a cycle per write but keeps the response path a single flop

  // accept each half only while no response is pending
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;

  // a parked half wins over the live bus
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_q | aw_take;
  wire w_have = w_held_q | w_take;
  // the write is performed in the cycle both halves are present
  wire wr_fire = aw_have & w_have & ~bvalid_q;
  wire [ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  // only byte lane 0 carries register bits; other lanes are dropped
  wire wr_lane0 = wr_strb[0];
  wire [7:0] wr_byte = wr_data[7:0];

  // ==========================================================================
  // write address decode
  // exact compares; a misaligned address selects nothing
  wire wr_sel_data = wr_fire & (wr_addr == OFF_PORT_OUTPUT_DATA);
  wire wr_sel_input = wr_fire & (wr_addr == OFF_PORT_PIN_INPUT);
  wire wr_sel_dir = wr_fire & (wr_addr == OFF_PIN_DIRECTION);
  wire wr_sel_drive = wr_fire & (wr_addr == OFF_DRIVE_STRENGTH_SELECT);
  wire wr_sel_pull = wr_fire & (wr_addr == OFF_PULL_ENABLE);
  wire wr_sel_pol = wr_fire & (wr_addr == OFF_PULL_AND_EDGE_POLARITY);
  wire wr_sel_ien = wr_fire & (wr_addr == OFF_EDGE_IRQ_ENABLE);
  wire wr_sel_flag = wr_fire & (wr_addr == OFF_EDGE_IRQ_FLAGS);
  // any other address answers slverr and writes nothing
  wire wr_mapped = wr_sel_data | wr_sel_input | wr_sel_dir | wr_sel_drive |
                   wr_sel_pull | wr_sel_pol | wr_sel_ien | wr_sel_flag;
  // input register accepts the write with okay but stores nothing
  wire [1:0] wr_resp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
  // lane 0 masked: still answered okay, but nothing is stored
  wire wr_en = wr_lane0;
  // ones written to the flag register clear those flags only;
  // a new edge in the same cycle still leaves its flag set
  wire [7:0] flag_clear = (wr_sel_flag & wr_en) ? wr_byte : 8'h00;

  // ==========================================================================
  // write channel sequencing
  // held flags clear only on completion, so a half taken early
  // is never lost while the other half is on its way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      // both halves here: complete and raise the response
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b1;
      bresp_q <= wr_resp;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================================
  // control registers
  // limitation: upper byte lanes are ignored, so a wide write
  // stores only its low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_output_data_q <= RST_PORT_OUTPUT_DATA;
      pin_direction_q <= RST_PIN_DIRECTION;
      drive_strength_select_q <= RST_DRIVE_STRENGTH_SELECT;
      pull_enable_q <= RST_PULL_ENABLE;
      pull_and_edge_polarity_q <= RST_PULL_AND_EDGE_POLARITY;
      edge_irq_enable_q <= RST_EDGE_IRQ_ENABLE;
    end else if (wr_en) begin
      if (wr_sel_data) begin
        port_output_data_q <= wr_byte;
      end
      if (wr_sel_dir) begin
        pin_direction_q <= wr_byte;
      end
      if (wr_sel_drive) begin
        drive_strength_select_q <= wr_byte;
      end
      if (wr_sel_pull) begin
        pull_enable_q <= wr_byte;
      end
      if (wr_sel_pol) begin
        pull_and_edge_polarity_q <= wr_byte;
      end
      if (wr_sel_ien) begin
        edge_irq_enable_q <= wr_byte;
      end
    end
  end

  // ==========================================================================
  // pin input path
  logic [PIN_COUNT-1:0] pin_level; // synchronised pin state

  // raw pins cross into the bus clock before any use; a change
  // reaches pin_level four edges later, and a one-cycle glitch never
  // does, because stages two and three must agree first
  pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pin_in),
    .pin_clean(pin_level)
  );

  // ==========================================================================
  // edge interrupt
  // one polarity bit sets both pull direction and active edge, so
  // changing the pull also changes which edge raises a flag
  edge_cfg_t edge_cfg;
  assign edge_cfg = '{rising: pull_and_edge_polarity_q, enable: edge_irq_enable_q};

  // the request is a level: high while any enabled flag is set,
  // low as soon as software clears the last one
  edge_flags u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(pin_level),
    .cfg(edge_cfg),
    .clear_mask(flag_clear),
    .flags(edge_irq_flags),
    .irq(port_irq)
  );

  // ==========================================================================
  // pad control
  // the routed function takes the pin where it owns it
  wire [PIN_COUNT-1:0] drive_oe = (alt_owns & alt_oe) | (~alt_owns & pin_direction_q);
  wire [PIN_COUNT-1:0] drive_val = (alt_owns & alt_out) | (~alt_owns & port_output_data_q);

  // drive selection follows whichever owner drives the pad
  wire [PIN_COUNT-1:0] weak_drive = drive_strength_select_q & drive_oe;

  // pulls are cut while the pad drives, so they never fight the driver
  wire [PIN_COUNT-1:0] pull_active = pull_enable_q & ~drive_oe;

  // polarity reaches the pad only while a pull is active
  wire [PIN_COUNT-1:0] pull_low = pull_and_edge_polarity_q & pull_active;

  // one bundle, one driver
  pad_ctrl_t pad;
  assign pad = '{out_value: drive_val, out_enable: drive_oe, reduced_drive: weak_drive,
                 pull_on: pull_active, pull_down: pull_low};

  assign pin_out = pad.out_value;
  assign pin_oe = pad.out_enable;
  assign pad_reduced_drive = pad.reduced_drive;
  assign pad_pull_on = pad.pull_on;
  assign pad_pull_down = pad.pull_down;

  // ==========================================================================
  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // taken at one edge, answered at the next; the address is decoded
  // straight off the bus, so araddr must stand until arready
  assign s_axi_arready = ~rvalid_q;
  wire ar_take = s_axi_arvalid & s_axi_arready;

  // read decode; output pins show their latch, inputs show the pin
  wire [7:0] data_view = (pin_direction_q & port_output_data_q) |
                         (~pin_direction_q & pin_level);

  // address compares; each selects one register
  wire rd_sel_data = (s_axi_araddr == OFF_PORT_OUTPUT_DATA);
  wire rd_sel_input = (s_axi_araddr == OFF_PORT_PIN_INPUT);
  wire rd_sel_dir = (s_axi_araddr == OFF_PIN_DIRECTION);
  wire rd_sel_drive = (s_axi_araddr == OFF_DRIVE_STRENGTH_SELECT);
  wire rd_sel_pull = (s_axi_araddr == OFF_PULL_ENABLE);
  wire rd_sel_pol = (s_axi_araddr == OFF_PULL_AND_EDGE_POLARITY);
  wire rd_sel_ien = (s_axi_araddr == OFF_EDGE_IRQ_ENABLE);
  wire rd_sel_flag = (s_axi_araddr == OFF_EDGE_IRQ_FLAGS);

  logic [7:0] rd_byte;
  logic rd_hit;

  // if/else-if decode of the read address
  // a miss reads zero and answers slverr
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (rd_sel_data) begin
      rd_byte = data_view;
    end else if (rd_sel_input) begin
      rd_byte = pin_level;
    end else if (rd_sel_dir) begin
      rd_byte = pin_direction_q;
    end else if (rd_sel_drive) begin
      rd_byte = drive_strength_select_q;
    end else if (rd_sel_pull) begin
      rd_byte = pull_enable_q;
    end else if (rd_sel_pol) begin
      rd_byte = pull_and_edge_polarity_q;
    end else if (rd_sel_ien) begin
      rd_byte = edge_irq_enable_q;
    end else if (rd_sel_flag) begin
      rd_byte = edge_irq_flags;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one read in flight; data held until rready
  // the byte is captured once, so a slow master reads a consistent
  // snapshot even if the pins move meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : gpio_port

// *** tb/gpio_port_props.sv ***
// checker: port-level properties of the gpio port
`timescale 1ns/1ps
module gpio_port_props
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] pad_reduced_drive,
  input wire logic [PIN_COUNT-1:0] pad_pull_on,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  input wire logic port_irq
);
  // =====
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write halves taken at the same edge
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read request above the register map (offsets 0x20 and up)
  sequence unmapped_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[5];
  endsequence
  // =====
  // pad controls and reset state
  reset_state_a: assert property ($rose(aresetn) |-> pin_oe == 8'h00 && !port_irq && !s_axi_bvalid)
    else $error("pins or request not idle after reset");
  drive_gate_a: assert property ((pad_reduced_drive & ~pin_oe) == 8'h00)
    else $error("reduced drive on a pin that is not driven");
  pull_gate_a: assert property ((pad_pull_on & pin_oe) == 8'h00)
    else $error("pull device active on a driven pin");
  pull_sel_a: assert property ((pad_pull_down & ~pad_pull_on) == 8'h00)
    else $error("pull-down selected without an active pull");
  // =====
  // bus handshake; a slip here would hang or corrupt software accesses
  write_answer_a: assert property (both_taken |=> s_axi_bvalid)
    else $error("write response late");
  busy_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  unmapped_rd_a: assert property (unmapped_read |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : gpio_port_props

bind gpio_port gpio_port_props gpio_port_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .pin_oe, .pad_reduced_drive, .pad_pull_on, .pad_pull_down, .port_irq);

// *** tb/pin_board.sv ***
// board model: the level each port pin shows to the port's input buffer
`timescale 1ns/1ps
module pin_board
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] pad_pull_on,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  input wire logic [PIN_COUNT-1:0] ext_val,
  input wire logic [PIN_COUNT-1:0] ext_drv,
  output logic [PIN_COUNT-1:0] pin_in
);
  // last level; a floating pin toggles so no stale value can pass
  logic [PIN_COUNT-1:0] last_q = 8'h00;
  // pull level: pull-down gives 0, pull-up gives 1
  wire [PIN_COUNT-1:0] pull_lvl = ~pad_pull_down;
  // port driver wins, then board driver, then pull, else floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
    | (~pin_oe & ~ext_drv & pad_pull_on & pull_lvl) | (~pin_oe & ~ext_drv & ~pad_pull_on & ~last_q);
  // remember the level for the floating case
  always_ff @(posedge aclk) begin
    last_q <= pin_in;
  end
endmodule : pin_board

// *** tb/port_h_pin_control_and_edge_irq_tb_top.sv ***
// testbench: register, pad and pin-interrupt checks of the gpio port
`timescale 1ns/1ps
module port_h_pin_control_and_edge_irq_tb_top;
  import gpio_pkg::*;
  // =====
  // table row: register, value written, value read back
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wr;
    logic [7:0] rd;
  } row_t;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [7:0] pin_in, pin_out, pin_oe, pad_reduced_drive, pad_pull_on, pad_pull_down, d;
  logic [7:0] alt_owns = 8'h00, alt_out = 8'h00, alt_oe = 8'h00, ext_val = 8'h3c, ext_drv = 8'hff;
  int err_count = 0, checks_done = 0;
  row_t rows [6] = '{
    '{OFF_PIN_DIRECTION, 8'ha5, 8'ha5},
    '{OFF_DRIVE_STRENGTH_SELECT, 8'h3c, 8'h3c},
    '{OFF_PULL_ENABLE, 8'h0f, 8'h0f},
    '{OFF_PULL_AND_EDGE_POLARITY, 8'h06, 8'h06},
    '{OFF_EDGE_IRQ_ENABLE, 8'h00, 8'h00},
    '{OFF_PORT_OUTPUT_DATA, 8'h0f, 8'h1d}
  };
  // 10 MHz clock
  always #50 aclk = ~aclk;
  gpio_port gpio_port_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .pin_in, .pin_out, .pin_oe, .alt_owns, .alt_out, .alt_oe,
    .pad_reduced_drive, .pad_pull_on, .pad_pull_down, .port_irq);
  pin_board pin_board_inst (.aclk, .pin_out, .pin_oe, .pad_pull_on, .pad_pull_down, .ext_val, .ext_drv,
    .pin_in);
  // =====
  // compare and verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // =====
  // bus master; slow delays the response ready to exercise holding
  task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'h0, v};
    s_axi_bready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= !slow;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
  // =====
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wr, r);
      check("bresp", r, RESP_OKAY);
      rd(rows[i].addr, d, r);
      check("readback", d, rows[i].rd);
    end
    check("pin_oe", pin_oe, 8'ha5);
    check("pin_out", pin_out & pin_oe, 8'h05);
    check("reduced", pad_reduced_drive, 8'h24);
    check("pull_on", pad_pull_on, 8'h0a);
    check("pull_down", pad_pull_down, 8'h02);
    // input register reads pins and ignores writes
    wr(OFF_PORT_PIN_INPUT, 8'hff, r);
    check("input_resp", r, RESP_OKAY);
    rd(OFF_PORT_PIN_INPUT, d, r);
    check("pin_input", d, 8'h1d);
    // routed function owns all pins
    alt_owns <= 8'hff;
    alt_oe <= 8'hff;
    alt_out <= 8'h5a;
    @(posedge aclk);
    check("alt_oe", pin_oe, 8'hff);
    check("alt_out", pin_out, 8'h5a);
    check("alt_reduced", pad_reduced_drive, 8'h3c);
    alt_owns <= 8'h00;
    alt_oe <= 8'h00;
    alt_out <= 8'h00;
    // unmapped accesses are refused
    wr(6'h20, 8'h5a, r);
    check("unmapped_w", r, RESP_SLVERR);
    rd(6'h24, d, r);
    check("unmapped_r", r, RESP_SLVERR);
    // edge flags with pins as inputs: 0-3 rising, 4-7 falling
    wr(OFF_PIN_DIRECTION, 8'h00, r);
    wr(OFF_PULL_AND_EDGE_POLARITY, 8'h0f, r);
    ext_val <= 8'h00;
    repeat (8) @(posedge aclk);
    wr(OFF_EDGE_IRQ_FLAGS, 8'hff, r);
    ext_val <= 8'hff;
    repeat (8) @(posedge aclk);
    rd(OFF_EDGE_IRQ_FLAGS, d, r);
    check("flags_rise", d, 8'h0f);
    check("irq_masked", port_irq, 8'h00);
    wr(OFF_EDGE_IRQ_ENABLE, 8'h08, r);
    check("irq_on", port_irq, 8'h01);
    wr(OFF_EDGE_IRQ_FLAGS, 8'h01, r);
    rd(OFF_EDGE_IRQ_FLAGS, d, r);
    check("flags_w1c", d, 8'h0e);
    wr(OFF_EDGE_IRQ_FLAGS, 8'h08, r);
    check("irq_off", port_irq, 8'h00);
    ext_val <= 8'h00;
    repeat (8) @(posedge aclk);
    rd(OFF_EDGE_IRQ_FLAGS, d, r);
    check("flags_fall", d, 8'hf6);
    // edges still seen while the port drives the pins
    wr(OFF_EDGE_IRQ_FLAGS, 8'hff, r);
    wr(OFF_PIN_DIRECTION, 8'hff, r);
    repeat (8) @(posedge aclk);
    rd(OFF_EDGE_IRQ_FLAGS, d, r);
    check("flags_out", d, 8'h0f);
    // slow response ready: slave must hold its answers
    slow = 1'b1;
    wr(OFF_EDGE_IRQ_ENABLE, 8'h00, r);
    rd(OFF_EDGE_IRQ_ENABLE, d, r);
    check("slow_read", d, 8'h00);
    slow = 1'b0;
    // lane 0 masked: answered okay, nothing stored
    s_axi_wstrb <= 4'he;
    wr(OFF_EDGE_IRQ_ENABLE, 8'hff, r);
    s_axi_wstrb <= 4'hf;
    check("strb_resp", r, RESP_OKAY);
    check("strb_irq", port_irq, 8'h00);
    // reset in mid-run returns every register to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("oe_reset", pin_oe, 8'h00);
    foreach (rows[i]) begin
      rd(rows[i].addr, d, r);
      check("reset_value", d, 8'h00);
    end
    rd(OFF_EDGE_IRQ_FLAGS, d, r);
    check("flags_reset", d, 8'h00);
    end_of_test();
  end
endmodule : port_h_pin_control_and_edge_irq_tb_top
